// ### hw/idt_pkg.sv
// constants and types for the instruction decode and timing block
// Notes on behaviour
// - accept 14-bit words, no extension words
// - classify into byte, bit, literal/control groups
// - one instruction cycle unless an exception
// - both calls take two cycles
// - all three returns take two cycles
// - jumps, branches, taken skips take two cycles
// - last cycle of flow change is no-op
// - indirect access to program memory adds cycle
// - instruction cycle is four oscillator clocks
// - file ops read, modify, write back result
// - read file register even when only writing
// - file address selects 0x00 to 0x7F
// - bit number picks one of eight bits
// - destination bit 0 to working, 1 to file
// - pointer number selects pointer 0 or 1
// - mode picks pre/post increment/decrement
package idt_pkg;
  localparam int unsigned IW        = 14;
  localparam int unsigned QPHASES   = 4;
  localparam logic [1:0]  Q_READ    = 2'h1;
  localparam logic [1:0]  Q_WRITE   = 2'h3;
  localparam int unsigned OP_HI     = 13;
  localparam int unsigned OP_LO     = 8;
  localparam int unsigned DEST_BIT  = 7;
  localparam int unsigned BIT_HI    = 9;
  localparam int unsigned BIT_LO    = 7;
  localparam int unsigned PTR_BIT   = 2;
  localparam int unsigned PTR_OFFB  = 6;
  localparam logic [6:0]  IND0_ADDR = 7'h00;
  localparam logic [6:0]  IND1_ADDR = 7'h01;
  localparam logic [1:0]  GRP_BYTE  = 2'h0;
  localparam logic [1:0]  GRP_BIT   = 2'h1;
  localparam logic [1:0]  GRP_LIT   = 2'h2;
  localparam logic [1:0]  GRP_CTL   = 2'h3;
  localparam logic [7:0]  RST_DATA  = 8'h00;

  typedef enum logic [2:0] {
    IDT_EXEC  = 3'b001,
    IDT_NOP   = 3'b010,
    IDT_EXTRA = 3'b100
  } idt_state_t;
endpackage : idt_pkg

// ### hw/idt_decoder.sv
// instruction decode, cycle timing and read-modify-write sequencing
`timescale 1ns/1ps
`default_nettype none
module idt_decoder
  import idt_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [IW-1:0] instr,
  input  wire logic [7:0]    file_rdata,
  input  wire logic          skip_cond,
  input  wire logic          ptr0_prog,
  input  wire logic          ptr1_prog,
  output logic               fetch_req,
  output logic               file_rd,
  output logic               file_wr,
  output logic [6:0]         file_addr,
  output logic [7:0]         file_wdata,
  output logic               w_wr,
  output logic [1:0]         group,
  output logic [2:0]         bit_num,
  output logic [10:0]        literal,
  output logic               ptr_sel,
  output logic [1:0]         ptr_mode,
  output logic               nop_cycle
);
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end

  logic [IW-1:0] ir_r;
  logic [1:0]    q_r;
  idt_state_t    st_r, st_nxt;

  wire [1:0] top2   = ir_r[13:12];
  wire [5:0] opc    = ir_r[OP_HI:OP_LO];
  // shifts and carry/borrow arithmetic live in the top opcode quarter
  wire       is_byte3 = (top2 == 2'h3) &&
                        (opc == 6'h35 || opc == 6'h36 || opc == 6'h37 ||
                         opc == 6'h3B || opc == 6'h3D);
  wire       is_byte= ((top2 == 2'h0) && (opc[3:0] != 4'h0 || ir_r[7])) ||
                      is_byte3;
  wire       is_bit = (top2 == 2'h1);
  wire       dest   = ir_r[DEST_BIT];
  wire [6:0] faddr  = ir_r[6:0];
  wire [2:0] bnum   = ir_r[BIT_HI:BIT_LO];
  wire is_call   = (top2 == 2'h2) && !ir_r[11];
  wire is_absolute_jump   = (top2 == 2'h2) &&  ir_r[11];
  wire is_bra    = (ir_r[13:9] == 5'h19);
  wire is_plp    = (ir_r[13:7] == 7'h63);
  wire is_bsel   = (ir_r[13:5] == 9'h001);
  wire [10:0] lit = (is_call || is_absolute_jump) ? ir_r[10:0] :
                    is_bra  ? {2'h0, ir_r[8:0]} :
                    is_plp  ? {4'h0, ir_r[6:0]} :
                    is_bsel ? {6'h00, ir_r[4:0]} : {3'h0, ir_r[7:0]};
  wire is_call_by_working_register  = (ir_r == 14'h000A);
  wire is_brw    = (ir_r == 14'h000B);
  wire is_ret    = (ir_r == 14'h0008) || (ir_r == 14'h0009) ||
                   (ir_r[13:8] == 6'h34);
  // branch and literal return count as control, bank select as literal
  wire [1:0] grp = is_byte ? GRP_BYTE : is_bit ? GRP_BIT :
                   (((top2 == 2'h3) && !is_bra && !is_ret) || is_bsel) ?
                   GRP_LIT : GRP_CTL;
  wire is_skip   = (is_byte && (opc == 6'h0B || opc == 6'h0F)) ||
                   (is_bit && ir_r[11]);
  wire flow      = is_call || is_absolute_jump || is_bra || is_call_by_working_register || is_brw ||
                   is_ret || (is_skip && skip_cond);
  // indirect location pointing at program memory
  wire ind_hit   = (is_byte || is_bit) &&
                   ((faddr == IND0_ADDR && ptr0_prog) ||
                    (faddr == IND1_ADDR && ptr1_prog));
  // file ops write back unless destination is working or the op is a bit test
  wire wr_file   = (is_byte && dest) || (is_bit && !ir_r[11]);
  wire end_q     = (q_r == 2'(QPHASES - 1));
  // fetch only when the next word will really load, so none is lost
  wire load_next = (st_r == IDT_NOP) ||
                   (!flow && !(st_r == IDT_EXEC && ind_hit));

  always_comb
  begin
    st_nxt = st_r;
    if (end_q)
      case (st_r)
        IDT_EXEC:  st_nxt = ind_hit ? IDT_EXTRA : flow ? IDT_NOP : IDT_EXEC;
        IDT_EXTRA: st_nxt = flow ? IDT_NOP : IDT_EXEC;
        IDT_NOP:   st_nxt = IDT_EXEC;
        default:   st_nxt = IDT_EXEC;
      endcase
  end

  wire exec_ph = (st_r == IDT_EXEC);
  // read always issued for file operands
  // the extra cycle reads again so the write-back uses settled data
  wire rd_nxt  = (exec_ph || st_r == IDT_EXTRA) && (is_byte || is_bit) &&
                 (q_r == Q_READ);
  wire last_x  = (st_nxt != IDT_EXTRA);
  wire wr_nxt  = (st_r != IDT_NOP) && wr_file && (q_r == Q_WRITE);
  wire [7:0] bmask = 8'h01 << bnum;
  wire [7:0] mod = is_bit ? (ir_r[10] ? (file_rdata | bmask)
                                      : (file_rdata & ~bmask))
                          : file_rdata;

  always_ff @(posedge clk or negedge rst_n_r)
    if (!rst_n_r)
    begin
      q_r        <= 2'h0;
      st_r       <= IDT_EXEC;
      ir_r       <= '0;
      fetch_req  <= 1'b0;
      file_rd    <= 1'b0;
      file_wr    <= 1'b0;
      file_addr  <= 7'h00;
      file_wdata <= RST_DATA;
      w_wr       <= 1'b0;
      group      <= GRP_BYTE;
      bit_num    <= 3'h0;
      literal    <= 11'h000;
      ptr_sel    <= 1'b0;
      ptr_mode   <= 2'h0;
      nop_cycle  <= 1'b0;
    end
    else
    begin
      q_r        <= q_r + 2'h1;
      st_r       <= st_nxt;
      if (end_q && st_nxt == IDT_EXEC)
        ir_r <= instr;
      fetch_req  <= (q_r == 2'h2) && load_next;
      file_rd    <= rd_nxt;
      file_wr    <= wr_nxt && last_x;
      w_wr       <= (st_r != IDT_NOP) && is_byte && !dest &&
                    (q_r == Q_WRITE) && last_x;
      file_addr  <= faddr;
      file_wdata <= mod;
      group      <= grp;
      bit_num    <= bnum;
      literal    <= lit;
      ptr_sel    <= ir_r[PTR_BIT] | ir_r[PTR_OFFB];
      ptr_mode   <= ir_r[1:0];
      nop_cycle  <= (st_nxt == IDT_NOP);
    end

  property p_phase_wrap;
    @(posedge clk) disable iff (!rst_n_r)
      (q_r == 2'h3) |=> (q_r == 2'h0);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap)
    else $error("phase counter did not wrap");

  property p_flow_nop;
    @(posedge clk) disable iff (!rst_n_r)
      (end_q && st_r == IDT_EXEC && flow && !ind_hit) |=> nop_cycle;
  endproperty
  a_flow_nop: assert property (p_flow_nop)
    else $error("flow change without no-op cycle");

  property p_nop_one;
    @(posedge clk) disable iff (!rst_n_r)
      (end_q && st_r == IDT_NOP) |=> (st_r == IDT_EXEC);
  endproperty
  a_nop_one: assert property (p_nop_one)
    else $error("no-op cycle longer than one");

  property p_single;
    @(posedge clk) disable iff (!rst_n_r)
      (end_q && st_r == IDT_EXEC && !flow && !ind_hit) |=>
        (st_r == IDT_EXEC);
  endproperty
  a_single: assert property (p_single)
    else $error("plain instruction took extra cycle");

  property p_extra;
    @(posedge clk) disable iff (!rst_n_r)
      (end_q && st_r == IDT_EXEC && ind_hit) |=> (st_r == IDT_EXTRA);
  endproperty
  a_extra: assert property (p_extra)
    else $error("indirect program access missed extra cycle");

  property p_read_first;
    @(posedge clk) disable iff (!rst_n_r)
      $rose(file_wr) |-> $past(file_rd, 2);
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("file write without earlier read");

  property p_dest_excl;
    @(posedge clk) disable iff (!rst_n_r)
      !(file_wr && w_wr);
  endproperty
  a_dest_excl: assert property (p_dest_excl)
    else $error("result written to both destinations");

  property p_addr_range;
    @(posedge clk) disable iff (!rst_n_r)
      file_rd |-> (file_addr == $past(ir_r[6:0]));
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("file address not from low seven bits");

  property p_fetch_pulse;
    @(posedge clk) disable iff (!rst_n_r)
      fetch_req |=> !fetch_req;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse)
    else $error("fetch request longer than one clock");

  property p_fetch_phase;
    @(posedge clk) disable iff (!rst_n_r)
      fetch_req |-> ($past(q_r) == 2'h2);
  endproperty
  a_fetch_phase: assert property (p_fetch_phase)
    else $error("fetch request outside its phase");

  property p_w_dest;
    @(posedge clk) disable iff (!rst_n_r)
      w_wr |-> $past(is_byte && !dest);
  endproperty
  a_w_dest: assert property (p_w_dest)
    else $error("working write without destination zero");

  property p_wr_src;
    @(posedge clk) disable iff (!rst_n_r)
      file_wr |-> $past(wr_file);
  endproperty
  a_wr_src: assert property (p_wr_src)
    else $error("file write from an operation without file result");

  property p_bit_mod;
    @(posedge clk) disable iff (!rst_n_r)
      (file_wr && group == GRP_BIT) |->
        (file_wdata[bit_num] == $past(ir_r[10]));
  endproperty
  a_bit_mod: assert property (p_bit_mod)
    else $error("bit operation wrote wrong bit value");

  property p_nop_quiet;
    @(posedge clk) disable iff (!rst_n_r)
      (st_r == IDT_NOP && q_r != 2'h0) |-> (!file_rd && !file_wr && !w_wr);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet)
    else $error("file or working access during no-op cycle");

  property p_extra_one;
    @(posedge clk) disable iff (!rst_n_r)
      (end_q && st_r == IDT_EXTRA) |=> (st_r != IDT_EXTRA);
  endproperty
  a_extra_one: assert property (p_extra_one)
    else $error("more than one extra cycle");
endmodule : idt_decoder
`default_nettype wire

// ### testbench/idt_prog_model.sv
// program memory model that hands out instruction words
`timescale 1ns/1ps
`default_nettype none
module idt_prog_model
  import idt_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     nrst,
  input  wire logic     fetch_req,
  output logic [IW-1:0] instr
);
  logic [IW-1:0] mem [0:15];
  logic [3:0]    pc_r;
  assign instr = mem[pc_r];
  always @(posedge clk or negedge nrst)
    if (!nrst)
      pc_r <= 4'h0;
    else if (fetch_req)
      pc_r <= #1 pc_r + 4'h1;
endmodule : idt_prog_model
`default_nettype wire

// ### testbench/instruction_decode_timing_tb_top.sv
// self-checking bench for instruction decode and timing
`timescale 1ns/1ps
`default_nettype none
module instruction_decode_timing_tb_top;
  import idt_pkg::*;
  logic          clk, nrst, skip_cond, ptr0_prog, ptr1_prog, ptr_sel;
  logic          fetch_req, file_rd, file_wr, w_wr, nop_cycle;
  logic [IW-1:0] instr;
  logic [7:0]    file_rdata, file_wdata;
  logic [6:0]    file_addr;
  logic [1:0]    group, ptr_mode;
  logic [2:0]    bit_num;
  logic [10:0]   literal;
  int            n_errors, n_checks, pend;

  idt_prog_model u_idt_prog_model (.clk(clk), .nrst(nrst),
    .fetch_req(fetch_req), .instr(instr));
  idt_decoder u_idt_decoder (.clk(clk), .nrst(nrst), .instr(instr),
    .file_rdata(file_rdata), .skip_cond(skip_cond), .ptr0_prog(ptr0_prog),
    .ptr1_prog(ptr1_prog), .fetch_req(fetch_req), .file_rd(file_rd),
    .file_wr(file_wr), .file_addr(file_addr), .file_wdata(file_wdata),
    .w_wr(w_wr), .group(group), .bit_num(bit_num), .literal(literal),
    .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .nop_cycle(nop_cycle));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic check(input bit ok, input string msg);
    n_checks++;
    if (!ok)
    begin
      $display("unexpected at %0t: %s", $time, msg);
      n_errors++;
    end
  endtask : check

  // counts clocks to the next fetch; the write of the previous word lands
  // in the first of them
  task automatic step(input logic [IW-1:0] w, input int len,
                      input logic [1:0] grp, input int lw, f, dst);
    int n = 0;
    int r = 0;
    int p = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1 && pend != 0)
        check({w_wr, file_wr} === (pend == 1 ? 2'b10 : 2'b01), "dest");
      r += int'(file_rd === 1'b1);
      p += int'(nop_cycle === 1'b1);
    end while (fetch_req !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      check(1'b0, "no fetch");
      conclude();
    end
    check(n == len, "cycles");
    check(group === grp, "group");
    if (lw > 0)
      check(literal === (11'(w) & 11'((1 << lw) - 1)), "literal");
    if (f > 0)
      check(file_addr === w[6:0] && r > 0 && (grp != GRP_BIT ||
            bit_num === w[9:7]), "file op");
    if (f < 2)
      check((p > 0) == (len > 4), "no-op");
    pend = dst;
  endtask : step

  task automatic restart(input logic [IW-1:0] prog [8]);
    int n = 0;
    for (int i = 0; i < 8; i++)
      u_idt_prog_model.mem[i] = prog[i];
    nrst = 1'b0;
    pend = 0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (fetch_req !== 1'b1 && n < 40);
    check(n < 40, "first fetch");
  endtask : restart

  task automatic t_plain;
    restart('{14'h07A5, 14'h0725, 14'h00FF, 14'h15A5, 14'h30C3, 14'h31DA,
              14'h0035, 14'h3DA5});
    step(14'h07A5, 4, GRP_BYTE, 0, 1, 2);
    step(14'h0725, 4, GRP_BYTE, 0, 1, 1);
    step(14'h00FF, 4, GRP_BYTE, 0, 1, 2);
    step(14'h15A5, 4, GRP_BIT, 0, 1, 2);
    step(14'h30C3, 4, GRP_LIT, 8, 0, 0);
    step(14'h31DA, 4, GRP_LIT, 7, 0, 0);
    step(14'h0035, 4, GRP_LIT, 5, 0, 0);
    step(14'h3DA5, 4, GRP_BYTE, 0, 1, 2);
    $display("t_plain done");
  endtask : t_plain

  task automatic t_flow;
    restart('{14'h2123, 14'h000A, 14'h0008, 14'h3455, 14'h0009, 14'h2ABC,
              14'h3345, 14'h000B});
    step(14'h2123, 8, GRP_CTL, 11, 0, 0);
    step(14'h000A, 8, GRP_CTL, 0, 0, 0);
    step(14'h0008, 8, GRP_CTL, 0, 0, 0);
    step(14'h3455, 8, GRP_CTL, 8, 0, 0);
    step(14'h0009, 8, GRP_CTL, 0, 0, 0);
    step(14'h2ABC, 8, GRP_CTL, 11, 0, 0);
    step(14'h3345, 8, GRP_CTL, 9, 0, 0);
    step(14'h000B, 8, GRP_CTL, 0, 0, 0);
    $display("t_flow done");
  endtask : t_flow

  task automatic t_skip;
    restart('{14'h1CA5, 14'h0BA5, 14'h18A5, 14'h0F25, 14'h0000, 14'h0000,
              14'h0000, 14'h0000});
    skip_cond = 1'b1;
    step(14'h1CA5, 8, GRP_BIT, 0, 1, 0);
    step(14'h0BA5, 8, GRP_BYTE, 0, 1, 0);
    skip_cond = 1'b0;
    step(14'h18A5, 4, GRP_BIT, 0, 1, 0);
    step(14'h0F25, 4, GRP_BYTE, 0, 1, 1);
    $display("t_skip done");
  endtask : t_skip

  task automatic t_indirect;
    restart('{14'h0780, 14'h0781, 14'h0701, 14'h0000, 14'h0000, 14'h0000,
              14'h0000, 14'h0000});
    ptr0_prog = 1'b1;
    step(14'h0780, 8, GRP_BYTE, 0, 2, 2);
    ptr1_prog = 1'b1;
    step(14'h0781, 8, GRP_BYTE, 0, 2, 2);
    ptr1_prog = 1'b0;
    step(14'h0701, 4, GRP_BYTE, 0, 1, 1);
    ptr0_prog = 1'b0;
    $display("t_indirect done");
  endtask : t_indirect

  initial
  begin
    nrst = 1'b0;
    skip_cond = 1'b0;
    ptr0_prog = 1'b0;
    ptr1_prog = 1'b0;
    file_rdata = 8'h3C;
    n_errors = 0;
    n_checks = 0;
    pend = 0;
    t_plain();
    t_flow();
    t_skip();
    t_indirect();
    conclude();
  end
endmodule : instruction_decode_timing_tb_top
`default_nettype wire
